// [tb/awcm_conv_model.sv]
`timescale 1ns/1ps
// Converter core: one result pulse per request
module awcm_conv_model
    import awcm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire logic [15:0] din,
    output awcm_result_t conv_result
);
    // Result pulse; data lines scramble between results
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            conv_result <= '0;
        else
            conv_result <= go ? {1'b1, din} : {1'b0, ~conv_result.data};
    end
endmodule // awcm_conv_model

// [tb/awcm_window_detector_sva.sv]
`timescale 1ns/1ps
`include "awcm_params.svh"
module awcm_window_detector_sva
    import awcm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire awcm_result_t conv_result,
    input wire awcm_route_t input_route,
    input wire logic window_hit_flag
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Address phase decode
    wire take = hsel & hready & htrans[1];
    wire rd_sel = take & !hwrite & (haddr[9:2] == `AWCM_IDX_INPUT_SEL);
    wire wr_ctrl = take & hwrite & (haddr[9:2] == `AWCM_IDX_CTRL);
    chk_sel_top_zero: assert property (rd_sel |=> hrdata[7:6] == 2'b00) else $error("select top bits set");
    chk_route_temp: assert property (input_route.code == `AWCM_SEL_TEMP |-> input_route.temp_sensor)
        else $error("temp route wrong");
    chk_route_supply: assert property (input_route.code == `AWCM_SEL_SUPPLY |-> input_route.supply_rail)
        else $error("supply route wrong");
    chk_route_pin_kind: assert property ($past(hresetn) |-> input_route.pin_or_reserved == (input_route.code[5:1] != 5'h0f))
        else $error("pin route wrong");
    chk_flag_cause: assert property ($rose(window_hit_flag) |-> $past(conv_result.valid))
        else $error("flag without result");
    chk_flag_clear: assert property ($fell(window_hit_flag) |-> $past(wr_ctrl, 2))
        else $error("flag lost");
    chk_rdata_idle: assert property (!$past(take & !hwrite) |-> hrdata == 32'h0000_0000) else $error("rdata not idle");
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready");
    cover property ($rose(window_hit_flag));
    cover property (input_route.temp_sensor);
    cover property (rd_sel);
endmodule // awcm_window_detector_sva
bind awcm_window_detector awcm_window_detector_sva i_awcm_window_detector_sva (.*);

// [tb/awcm_window_detector_tb_top.sv]
`timescale 1ns/1ps
`include "awcm_params.svh"
module awcm_window_detector_tb_top
    import awcm_pkg::*;
;
    logic hclk = 0;
    logic hresetn = 0;
    logic hsel = 0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 0;
    logic [31:0] hwdata = '0;
    logic go = 0;
    logic [15:0] din = '0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    awcm_result_t conv_result;
    awcm_route_t input_route;
    logic window_hit_flag;
    logic irq;
    int n_mismatch = 0;
    int samples_checked = 0;
    // 25 MHz clock
    always #20 hclk = ~hclk;
    awcm_conv_model i_awcm_conv_model (.*);
    awcm_window_detector i_awcm_window_detector (.*, .hsize(3'b010), .hready(hreadyout));
    task give_verdict;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                n_mismatch++;
                give_verdict;
            end
            @(posedge hclk);
        end
    endtask
    // Single word transfer; reads compare against d
    task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {22'h0, i, 2'b00};
        ready;
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        ready;
        if (!w)
            chk(hrdata, d);
    endtask
    // Clear flag and status, send one result, check the flag
    task conv(input logic [15:0] v, input logic e);
        xfer(1, `AWCM_IDX_CTRL, 32'h0);
        xfer(1, `AWCM_IDX_IRQ_STATUS, 32'h1);
        go <= 1'b1;
        din <= v;
        @(posedge hclk);
        go <= 1'b0;
        repeat (3) @(posedge hclk);
        chk(window_hit_flag, e);
    endtask
    // Main sequence
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(0, `AWCM_IDX_INPUT_SEL, 32'h0);
        xfer(0, `AWCM_IDX_UPPER_LO, 32'h0000_00ff);
        xfer(0, `AWCM_IDX_UPPER_HI, 32'h0000_00ff);
        xfer(0, `AWCM_IDX_LOWER_HI, 32'h0);
        xfer(0, `AWCM_IDX_LOWER_LO, 32'h0);
        xfer(0, `AWCM_IDX_CTRL, 32'h0);
        xfer(0, `AWCM_IDX_IRQ_STATUS, 32'h0);
        xfer(0, `AWCM_IDX_IRQ_MASK, 32'h0);
        xfer(0, 8'hff, 32'h0);
        conv(16'hffff, 0);
        xfer(1, `AWCM_IDX_INPUT_SEL, 32'h0000_00ff);
        xfer(0, `AWCM_IDX_INPUT_SEL, 32'h0000_003f);
        xfer(1, `AWCM_IDX_INPUT_SEL, 32'h0000_001e);
        repeat (2) @(posedge hclk);
        chk(input_route, {`AWCM_SEL_TEMP, 3'b100});
        xfer(1, `AWCM_IDX_INPUT_SEL, 32'h0000_001f);
        repeat (2) @(posedge hclk);
        chk(input_route, {`AWCM_SEL_SUPPLY, 3'b010});
        xfer(1, `AWCM_IDX_UPPER_HI, 32'h0000_0012);
        xfer(1, `AWCM_IDX_UPPER_LO, 32'h0000_0034);
        xfer(0, `AWCM_IDX_UPPER_HI, 32'h0000_0012);
        xfer(0, `AWCM_IDX_UPPER_LO, 32'h0000_0034);
        xfer(1, `AWCM_IDX_LOWER_LO, 32'h0000_0010);
        xfer(1, `AWCM_IDX_IRQ_MASK, 32'h1);
        conv(16'h1235, 1);
        chk(irq, 1);
        xfer(0, `AWCM_IDX_CTRL, 32'h1);
        xfer(1, `AWCM_IDX_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk(irq, 0);
        conv(16'h1234, 0);
        conv(16'h0010, 0);
        xfer(1, `AWCM_IDX_IRQ_MASK, 32'h0);
        conv(16'h000f, 1);
        chk(irq, 0);
        xfer(0, `AWCM_IDX_IRQ_STATUS, 32'h1);
        xfer(1, `AWCM_IDX_LOWER_HI, 32'h0000_0020);
        conv(16'h1235, 1);
        conv(16'h1234, 0);
        conv(16'h1fff, 1);
        conv(16'h2000, 1);
        conv(16'h2010, 0);
        give_verdict;
    end
endmodule // awcm_window_detector_tb_top

// [verilog/awcm_params.svh]
`ifndef AWCM_PARAMS_SVH
`define AWCM_PARAMS_SVH

// Register word indices (printed offsets are not all multiples of four: byte address is index times four)
`define AWCM_IDX_INPUT_SEL 8'hbb
`define AWCM_IDX_UPPER_LO 8'hc3
`define AWCM_IDX_UPPER_HI 8'hc4
`define AWCM_IDX_LOWER_LO 8'hc5
`define AWCM_IDX_LOWER_HI 8'hc6
`define AWCM_IDX_CTRL 8'hc7
`define AWCM_IDX_IRQ_STATUS 8'hc8
`define AWCM_IDX_IRQ_MASK 8'hc9

// Reset values
`define AWCM_RST_INPUT_SEL 8'h00
`define AWCM_RST_UPPER 8'hff
`define AWCM_RST_LOWER 8'h00
`define AWCM_RST_MASK 8'h00

// Field positions
`define AWCM_SEL_MSB 5
`define AWCM_CTRL_HIT_BIT 0
`define AWCM_IRQ_HIT_BIT 0

// Select codes with fixed meaning
`define AWCM_SEL_TEMP 6'h1e
`define AWCM_SEL_SUPPLY 6'h1f

`endif

// [verilog/awcm_pkg.sv]
package awcm_pkg;

    // Result arriving from the converter core
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } awcm_result_t;

    // Routing decision for the positive input
    typedef struct packed {
        logic [5:0] code;
        logic temp_sensor;
        logic supply_rail;
        logic pin_or_reserved;
    } awcm_route_t;

    typedef enum logic [1:0] {
        AWCM_BUS_IDLE,
        AWCM_BUS_WRITE,
        AWCM_BUS_READ
    } awcm_bus_t;

endpackage

// [verilog/awcm_window_detector.sv]
`timescale 1ns/1ps
`include "awcm_params.svh"

// Functional notes
// - Every new converter result is compared against the limits, no software needed.
// - A window match sets the hit flag in control; usable for interrupt or polling.
// - Upper and lower limits are each a high and a low byte register pair.
// - Upper word high-order bits in high byte 7:0, low-order bits in low byte 7:0.
// - Inside or outside window chosen only by relative limit contents, no mode bit.
// - Input select bits 7:6 read 00b and ignore writes; bits 5:0 writable.
// - Select code 011110 routes temperature sensor, 011111 supply rail; others by package.
module awcm_window_detector
    import awcm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire awcm_result_t conv_result,
    output awcm_route_t input_route,
    output logic window_hit_flag,
    output logic irq
);

    // Configuration state
    logic [5:0] sel_ff;
    logic [7:0] upper_hi_ff;
    logic [7:0] upper_lo_ff;
    logic [7:0] lower_hi_ff;
    logic [7:0] lower_lo_ff;

    // Event and interrupt state
    logic hit_ff;
    logic irq_stat_ff;
    logic irq_mask_ff;
    logic irq_ff;
    awcm_route_t route_ff;

    // Bus state
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    awcm_bus_t bus_ff;
    logic [7:0] addr_ff;

    // Address phase capture
    wire addr_take = hsel & hready & htrans[1];
    wire awcm_bus_t nxt_bus = !addr_take ? AWCM_BUS_IDLE : (hwrite ? AWCM_BUS_WRITE : AWCM_BUS_READ);
    wire [7:0] word_idx = haddr[9:2];
    wire [7:0] nxt_addr = word_idx;

    // Decode of a word index, used for writes and for reads
    function automatic logic hit_idx(input logic [7:0] idx, input logic [7:0] reg_idx);
        hit_idx = (idx == reg_idx);
    endfunction

    // Data-phase write strobes per register
    wire wr = (bus_ff == AWCM_BUS_WRITE);
    wire [7:0] wb = hwdata[7:0];
    wire wr_sel = wr & hit_idx(addr_ff, `AWCM_IDX_INPUT_SEL);
    wire wr_uhi = wr & hit_idx(addr_ff, `AWCM_IDX_UPPER_HI);
    wire wr_ulo = wr & hit_idx(addr_ff, `AWCM_IDX_UPPER_LO);
    wire wr_lhi = wr & hit_idx(addr_ff, `AWCM_IDX_LOWER_HI);
    wire wr_llo = wr & hit_idx(addr_ff, `AWCM_IDX_LOWER_LO);

    // Control and interrupt write strobes
    wire wr_ctl = wr & hit_idx(addr_ff, `AWCM_IDX_CTRL);
    wire wr_sts = wr & hit_idx(addr_ff, `AWCM_IDX_IRQ_STATUS);
    wire wr_msk = wr & hit_idx(addr_ff, `AWCM_IDX_IRQ_MASK);

    // Limit words, high byte over low byte
    wire [15:0] upper_word = {upper_hi_ff, upper_lo_ff};
    wire [15:0] lower_word = {lower_hi_ff, lower_lo_ff};

    // Window test; mode follows from limit order alone
    wire lower_above = lower_word > upper_word;

    // Strict unsigned compares against both limits
    wire res_above = conv_result.data > upper_word;
    wire res_below = conv_result.data < lower_word;
    wire inside_hit = res_above & res_below;
    wire outside_hit = res_above | res_below;
    wire window_match = conv_result.valid & (lower_above ? inside_hit : outside_hit);

    // Flag: hardware set wins over software clear
    wire ctl_clr = wr_ctl & ~wb[`AWCM_CTRL_HIT_BIT];
    wire nxt_hit = window_match | (hit_ff & ~ctl_clr);

    // Interrupt status, write one to clear; set wins
    wire sts_clr = wr_sts & wb[`AWCM_IRQ_HIT_BIT];
    wire nxt_irq_stat = window_match | (irq_stat_ff & ~sts_clr);
    wire nxt_irq_mask = wr_msk ? wb[`AWCM_IRQ_HIT_BIT] : irq_mask_ff;
    wire nxt_irq = nxt_irq_stat & nxt_irq_mask;

    // Writable select field only
    wire [5:0] nxt_sel = wr_sel ? wb[`AWCM_SEL_MSB:0] : sel_ff;
    wire [7:0] nxt_uhi = wr_uhi ? wb : upper_hi_ff;
    wire [7:0] nxt_ulo = wr_ulo ? wb : upper_lo_ff;
    wire [7:0] nxt_lhi = wr_lhi ? wb : lower_hi_ff;
    wire [7:0] nxt_llo = wr_llo ? wb : lower_lo_ff;

    // Input routing decode
    awcm_route_t nxt_route;
    assign nxt_route.code = nxt_sel;
    assign nxt_route.temp_sensor = (nxt_sel == `AWCM_SEL_TEMP);
    assign nxt_route.supply_rail = (nxt_sel == `AWCM_SEL_SUPPLY);
    assign nxt_route.pin_or_reserved = ~nxt_route.temp_sensor & ~nxt_route.supply_rail;

    // Read mux, registered in the address phase
    wire [7:0] rd_idx = word_idx;
    wire [7:0] rd_byte =
        hit_idx(rd_idx, `AWCM_IDX_INPUT_SEL) ? {2'b00, nxt_sel} :
        hit_idx(rd_idx, `AWCM_IDX_UPPER_HI) ? nxt_uhi :
        hit_idx(rd_idx, `AWCM_IDX_UPPER_LO) ? nxt_ulo :
        hit_idx(rd_idx, `AWCM_IDX_LOWER_HI) ? nxt_lhi :
        hit_idx(rd_idx, `AWCM_IDX_LOWER_LO) ? nxt_llo :
        hit_idx(rd_idx, `AWCM_IDX_CTRL) ? {7'h00, nxt_hit} :
        hit_idx(rd_idx, `AWCM_IDX_IRQ_STATUS) ? {7'h00, nxt_irq_stat} :
        hit_idx(rd_idx, `AWCM_IDX_IRQ_MASK) ? {7'h00, nxt_irq_mask} : 8'h00;

    // Read data only for a read data phase, zero otherwise
    wire [31:0] nxt_hrdata = (addr_take & ~hwrite) ? {24'h0000_00, rd_byte} : 32'h0000_0000;

    // Zero wait states, always OKAY
    wire nxt_hreadyout = 1'b1;
    wire nxt_hresp = 1'b0;

    // Transfer kind of the pending data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_ff <= AWCM_BUS_IDLE;
        end
        else
        begin
            bus_ff <= nxt_bus;
        end
    end

    // Word index of the pending data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_ff <= 8'h00;
        end
        else
        begin
            addr_ff <= nxt_addr;
        end
    end

    // Read data, loaded at the address edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_ff <= 32'h0000_0000;
        end
        else
        begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    // Ready output, high from reset on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_ff <= 1'b1;
        end
        else
        begin
            hreadyout_ff <= nxt_hreadyout;
        end
    end

    // Response output, OKAY only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hresp_ff <= 1'b0;
        end
        else
        begin
            hresp_ff <= nxt_hresp;
        end
    end

    // Positive input select field
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_ff <= 6'h00;
        end
        else
        begin
            sel_ff <= nxt_sel;
        end
    end

    // Upper limit high byte
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            upper_hi_ff <= `AWCM_RST_UPPER;
        end
        else
        begin
            upper_hi_ff <= nxt_uhi;
        end
    end

    // Upper limit low byte
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            upper_lo_ff <= `AWCM_RST_UPPER;
        end
        else
        begin
            upper_lo_ff <= nxt_ulo;
        end
    end

    // Lower limit high byte
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lower_hi_ff <= `AWCM_RST_LOWER;
        end
        else
        begin
            lower_hi_ff <= nxt_lhi;
        end
    end

    // Lower limit low byte
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lower_lo_ff <= `AWCM_RST_LOWER;
        end
        else
        begin
            lower_lo_ff <= nxt_llo;
        end
    end

    // Interrupt mask bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_mask_ff <= 1'b0;
        end
        else
        begin
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // Sticky window hit flag
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hit_ff <= 1'b0;
        end
        else
        begin
            hit_ff <= nxt_hit;
        end
    end

    // Sticky interrupt status bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_ff <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    // Level interrupt, status and mask
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= nxt_irq;
        end
    end

    // Registered input routing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            route_ff <= '0;
        end
        else
        begin
            route_ff <= nxt_route;
        end
    end

    // Bus outputs
    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;

    // Routing and event outputs
    assign input_route = route_ff;
    assign window_hit_flag = hit_ff;
    assign irq = irq_ff;

endmodule // awcm_window_detector
